// ==== rtl/ipc_pkg.sv ====
// constants and types shared by both ends of the input interface configuration link
`default_nettype none
package ipc_pkg;
  // register indices on the link; byte address on the bus is four times the index
  localparam logic [3:0]  IDX_CONF_TWO     = 4'h0;
  localparam logic [3:0]  IDX_RESIZE_START = 4'h1;
  localparam logic [3:0]  IDX_CLIP      = 4'h2;
  localparam logic [3:0]  IDX_UNDERFLOW = 4'h3;
  localparam logic [3:0]  IDX_DIVIDER   = 4'h4;
  localparam logic [3:0]  IDX_DEFECT_LIVE  = 4'h5;
  localparam logic [3:0]  IDX_DEFECT_MEM   = 4'h6;
  localparam logic [3:0]  IDX_STAT_RESIZE  = 4'h7;
  localparam logic [3:0]  IDX_STAT_START = 4'h8;
  localparam logic [3:0]  IDX_LAST      = 4'h8;
  // controller-side registers on the bus
  localparam logic [11:0] ADDR_CTRL     = 12'h040;
  localparam logic [11:0] ADDR_STATUS   = 12'h044;
  // second configuration fields
  localparam int CONF_TWO_ORIGIN_BIT = 0;
  localparam int CONF_TWO_HPOL_BIT   = 1;
  localparam int CONF_TWO_VPOL_BIT   = 2;
  localparam int CONF_TWO_TYPE_BIT   = 3;
  localparam int CONF_TWO_WQUAL_BIT  = 4;
  localparam int CONF_TWO_DARK_BIT   = 5;
  localparam logic [31:0] CONF_TWO_MASK  = 32'h0000_003f;
  localparam logic [31:0] CONF_TWO_RESET = 32'h0000_0000;
  // resize start registers: 13-bit start field and a realign strobe bit
  localparam int START_ALIGN_BIT  = 13;
  localparam logic [31:0] START_MASK   = 32'h0000_1fff;
  localparam logic [31:0] START_RESET  = 32'h0000_0000;
  // clipping value
  localparam logic [31:0] CLIP_MASK    = 32'h0000_0fff;
  localparam logic [31:0] CLIP_RESET   = 32'h0000_0fff;
  // underflow flag
  localparam int UNDERFLOW_BIT    = 0;
  // rate divider: upper byte is M-1, lower byte is N-1
  localparam logic [31:0] DIV_MASK     = 32'h0000_ffff;
  localparam logic [31:0] DIV_RESET    = 32'h0000_0000;
  // defect correction: enable bit 12, threshold 11-0
  localparam int DEFECT_ON_BIT    = 12;
  localparam logic [31:0] DEFECT_MASK  = 32'h0000_1fff;
  localparam logic [31:0] DEFECT_RESET = 32'h0000_0000;
  // statistics resize: drop bit 9, smoothing bit 8, step 6-0
  localparam int STAT_DROP_BIT    = 9;
  localparam int STAT_SMOOTH_BIT  = 8;
  localparam logic [31:0] STAT_MASK    = 32'h0000_037f;
  localparam logic [31:0] STAT_RESET   = 32'h0000_0010;
  // controller control register fields
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_DIVSEL_BIT  = 1;
  localparam int CTRL_SRC2_BIT    = 2;
  localparam logic [31:0] CTRL_MASK    = 32'h0000_0007;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  // controller sequencer, gray coded along idle -> request -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_DONE = 2'b11
  } ipc_state_type;
endpackage
`default_nettype wire

// ==== rtl/ipc_link_if.sv ====
// link between the configuration controller and the configuration bank
`default_nettype none
interface ipc_link_if;
  logic        req;                  // request, held until ack
  logic        we;                   // 1 write, 0 read
  logic [3:0]  idx;                  // register index
  logic [31:0] wdata;                // write data
  logic        ack;                  // one-cycle answer
  logic [31:0] rdata;                // read data, valid with ack
  logic        if_enable;            // interface enable from first configuration
  logic        rate_divider_select;  // divider in use
  logic        input_source_bit_two; // source bit of first configuration
  logic        read_underflow_flag;  // mirror of the sticky flag
  modport dev (input req, we, idx, wdata, if_enable, rate_divider_select,
               input_source_bit_two, output ack, rdata, read_underflow_flag);
  modport ctl (output req, we, idx, wdata, if_enable, rate_divider_select,
               input_source_bit_two, input ack, rdata, read_underflow_flag);
endinterface
`default_nettype wire

// ==== rtl/ipc_bank.sv ====
// configuration bank of the image pipe input interface, device end of the link
`default_nettype none
module ipc_bank
  import ipc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link to the controller
  ipc_link_if.dev          link,
  // sync and pixel inputs
  input  wire logic        hsync_in,
  input  wire logic        vsync_in,
  input  wire logic        data_valid,
  input  wire logic        ext_write_enable,
  input  wire logic        port_vstart,
  input  wire logic        sensor_vstart,
  input  wire logic [11:0] gained_sample,
  input  wire logic        underflow_corrupt,
  // conditioned pipe outputs
  output logic             hsync_active,
  output logic             vsync_active,
  output logic             pixel_valid,
  output logic             interface_irq,
  output logic [11:0]      clipped_sample,
  output logic             read_rate_tick,
  output logic             sync_realign,
  output logic             statistics_sync_realign,
  // configuration seen by the pipe
  output logic             input_type_select,
  output logic             dark_subtract_order,
  output logic [12:0]      resize_start_field,
  output logic [12:0]      statistics_resize_start,
  output logic             live_correction_on,
  output logic [11:0]      live_defect_limit,
  output logic             memory_correction_on,
  output logic [11:0]      memory_defect_limit,
  output logic             pixel_drop_select,
  output logic             smoothing_select,
  output logic [6:0]       resize_step
);
  logic [31:0] conf_two_reg;    // second configuration
  logic [31:0] start_reg;       // main resize start
  logic [31:0] clip_reg;        // clipping value
  logic        underflow_reg;   // sticky underflow flag
  logic [31:0] div_reg;         // rate divider
  logic [31:0] defect_live_reg; // live path correction
  logic [31:0] defect_mem_reg;  // memory path correction
  logic [31:0] stat_reg;        // statistics resize control
  logic [31:0] stat_start_reg;  // statistics resize start
  logic        ack_reg;         // link answer
  logic [31:0] rdata_reg;       // captured read data
  logic [8:0]  acc_reg;         // rate accumulator, below N + M
  logic [8:0]  acc_next;        // accumulator after this cycle
  logic [8:0]  div_m;           // M = upper byte + 1
  logic [8:0]  div_n;           // N = lower byte + 1
  logic        take;            // request accepted this cycle
  logic        wr;              // write accepted this cycle

  // read image of a register; reserved bits come back zero
  function automatic logic [31:0] read_image(input logic [3:0] i);
    unique case (i)
      IDX_CONF_TWO:     read_image = conf_two_reg & CONF_TWO_MASK;
      IDX_RESIZE_START: read_image = start_reg & START_MASK;
      IDX_CLIP:         read_image = clip_reg & CLIP_MASK;
      IDX_UNDERFLOW:    read_image = {31'h0000_0000, underflow_reg};
      IDX_DIVIDER:      read_image = div_reg & DIV_MASK;
      IDX_DEFECT_LIVE:  read_image = defect_live_reg & DEFECT_MASK;
      IDX_DEFECT_MEM:   read_image = defect_mem_reg & DEFECT_MASK;
      IDX_STAT_RESIZE:  read_image = stat_reg & STAT_MASK;
      IDX_STAT_START:   read_image = stat_start_reg & START_MASK;
      default:          read_image = 32'h0000_0000;
    endcase
  endfunction

  // a request is taken once, in the cycle before its ack
  assign take = link.req & ~ack_reg;
  assign wr   = take & link.we;

  // link answer: ack one cycle after the request is seen, data with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= take;
      if (take) begin
        rdata_reg <= link.we ? 32'h0000_0000 : read_image(link.idx);
      end
    end
  end

  // software writes; stored bits are masked so reserved ones never stick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conf_two_reg    <= CONF_TWO_RESET;
      start_reg       <= START_RESET;
      clip_reg        <= CLIP_RESET;
      div_reg         <= DIV_RESET;
      defect_live_reg <= DEFECT_RESET;
      defect_mem_reg  <= DEFECT_RESET;
      stat_reg        <= STAT_RESET;
      stat_start_reg  <= START_RESET;
    end else if (wr) begin
      unique case (link.idx)
        IDX_CONF_TWO:     conf_two_reg    <= link.wdata & CONF_TWO_MASK;
        IDX_RESIZE_START: start_reg       <= link.wdata & START_MASK;
        IDX_CLIP:         clip_reg        <= link.wdata & CLIP_MASK;
        IDX_DIVIDER:      div_reg         <= link.wdata & DIV_MASK;
        IDX_DEFECT_LIVE:  defect_live_reg <= link.wdata & DEFECT_MASK;
        IDX_DEFECT_MEM:   defect_mem_reg  <= link.wdata & DEFECT_MASK;
        IDX_STAT_RESIZE:  stat_reg        <= link.wdata & STAT_MASK;
        IDX_STAT_START:   stat_start_reg  <= link.wdata & START_MASK;
        default:          ;
      endcase
    end
  end

  // realign strobes: the bit is a command, it is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_realign            <= 1'b0;
      statistics_sync_realign <= 1'b0;
    end else begin
      sync_realign <= wr & (link.idx == IDX_RESIZE_START) & link.wdata[START_ALIGN_BIT];
      statistics_sync_realign <= wr & (link.idx == IDX_STAT_START)
                                 & link.wdata[START_ALIGN_BIT];
    end
  end

  // sticky underflow flag; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_reg <= 1'b0;
    end else if (underflow_corrupt) begin
      underflow_reg <= 1'b1;
    end else if (wr && link.idx == IDX_UNDERFLOW && link.wdata[UNDERFLOW_BIT]) begin
      underflow_reg <= 1'b0;
    end
  end

  // fractional rate generator; software must keep M over N at most one half
  assign div_m = {1'b0, div_reg[15:8]} + 9'h001;
  assign div_n = {1'b0, div_reg[7:0]} + 9'h001;
  assign acc_next = acc_reg + div_m;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg        <= 9'h000;
      read_rate_tick <= 1'b0;
    end else if (!link.rate_divider_select) begin
      acc_reg        <= 9'h000;
      read_rate_tick <= 1'b1;
    end else if (acc_next >= div_n) begin
      acc_reg        <= acc_next - div_n;
      read_rate_tick <= 1'b1;
    end else begin
      acc_reg        <= acc_next;
      read_rate_tick <= 1'b0;
    end
  end

  // sync conditioning, pixel qualification and interrupt source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsync_active  <= 1'b0;
      vsync_active  <= 1'b0;
      pixel_valid   <= 1'b0;
      interface_irq <= 1'b0;
    end else begin
      hsync_active  <= hsync_in ^ conf_two_reg[CONF_TWO_HPOL_BIT];
      vsync_active  <= vsync_in ^ conf_two_reg[CONF_TWO_VPOL_BIT];
      if (conf_two_reg[CONF_TWO_WQUAL_BIT] && link.if_enable) begin
        pixel_valid <= data_valid & ext_write_enable;
      end else begin
        pixel_valid <= data_valid;
      end
      interface_irq <= conf_two_reg[CONF_TWO_ORIGIN_BIT] ? sensor_vstart : port_vstart;
    end
  end

  // clip after gain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clipped_sample <= 12'h000;
    end else if (gained_sample > clip_reg[11:0]) begin
      clipped_sample <= clip_reg[11:0];
    end else begin
      clipped_sample <= gained_sample;
    end
  end

  // configuration outputs, registered so the pipe sees flop outputs only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_type_select       <= 1'b0;
      dark_subtract_order     <= 1'b0;
      resize_start_field      <= 13'h0000;
      statistics_resize_start <= 13'h0000;
      live_correction_on      <= 1'b0;
      live_defect_limit       <= 12'h000;
      memory_correction_on    <= 1'b0;
      memory_defect_limit     <= 12'h000;
      pixel_drop_select       <= 1'b0;
      smoothing_select        <= 1'b0;
      resize_step             <= STAT_RESET[6:0];
    end else begin
      // a luma/chroma type is meaningless when the source bit is set
      input_type_select <= conf_two_reg[CONF_TWO_TYPE_BIT] & ~link.input_source_bit_two;
      dark_subtract_order     <= conf_two_reg[CONF_TWO_DARK_BIT];
      resize_start_field      <= start_reg[12:0];
      statistics_resize_start <= stat_start_reg[12:0];
      live_correction_on      <= defect_live_reg[DEFECT_ON_BIT];
      live_defect_limit       <= defect_live_reg[11:0];
      memory_correction_on    <= defect_mem_reg[DEFECT_ON_BIT];
      memory_defect_limit     <= defect_mem_reg[11:0];
      pixel_drop_select       <= stat_reg[STAT_DROP_BIT];
      smoothing_select        <= stat_reg[STAT_SMOOTH_BIT];
      resize_step             <= stat_reg[6:0];
    end
  end

  assign link.ack                 = ack_reg;
  assign link.rdata               = rdata_reg;
  assign link.read_underflow_flag = underflow_reg;
endmodule
`default_nettype wire

// ==== rtl/ipc_ctrl.sv ====
// apb controller that drives the configuration bank over the link
`default_nettype none
module ipc_ctrl
  import ipc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // link to the bank
  ipc_link_if.ctl          link
);
  ipc_state_type state_reg;   // sequencer
  logic        req_reg;       // link request
  logic        we_reg;        // link direction
  logic [3:0]  idx_reg;       // link index
  logic [31:0] wdata_reg;     // link write data
  logic [31:0] ctrl_reg;      // enable, divider select, source bit
  logic        access;        // apb access phase not yet answered
  logic        in_window;     // address falls on a bank register
  logic [3:0]  win_idx;       // index from address

  assign win_idx   = paddr[5:2];
  assign in_window = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) && (win_idx <= IDX_LAST);
  assign access    = psel & penable & ~pready;

  // sequencer: bank accesses wait for ack, local ones answer at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      req_reg   <= 1'b0;
      we_reg    <= 1'b0;
      idx_reg   <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      pready    <= 1'b0;
      prdata    <= 32'h0000_0000;
      pslverr   <= 1'b0;
      ctrl_reg  <= CTRL_RESET;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (access && in_window) begin
            req_reg   <= 1'b1; // held until the bank answers
            we_reg    <= pwrite;
            idx_reg   <= win_idx;
            wdata_reg <= pwdata;
            state_reg <= ST_REQ;
          end else if (access) begin
            pready    <= 1'b1;
            state_reg <= ST_DONE;
            prdata    <= 32'h0000_0000;
            if (paddr == ADDR_CTRL) begin
              if (pwrite) begin
                ctrl_reg <= pwdata & CTRL_MASK;
              end else begin
                prdata <= ctrl_reg;
              end
            end else if (paddr == ADDR_STATUS) begin
              prdata <= {31'h0000_0000, link.read_underflow_flag};
            end else begin
              pslverr <= 1'b1; // unmapped address
            end
          end
        end
        ST_REQ: begin
          if (link.ack) begin
            req_reg   <= 1'b0;
            prdata    <= we_reg ? 32'h0000_0000 : link.rdata;
            pready    <= 1'b1;
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          // one-cycle answer; the master drops penable after it
          pready    <= 1'b0;
          pslverr   <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.req                  = req_reg;
  assign link.we                   = we_reg;
  assign link.idx                  = idx_reg;
  assign link.wdata                = wdata_reg;
  assign link.if_enable            = ctrl_reg[CTRL_ENABLE_BIT];
  assign link.rate_divider_select  = ctrl_reg[CTRL_DIVSEL_BIT];
  assign link.input_source_bit_two = ctrl_reg[CTRL_SRC2_BIT];
endmodule
`default_nettype wire

// ==== bench/ipc_chk.sv ====
// link protocol and register rule checks for the configuration link
`default_nettype none
module ipc_chk
  import ipc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link request side
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [3:0]  idx,
  input  wire logic [31:0] wdata,
  // link answer side
  input  wire logic        ack,
  input  wire logic [31:0] rdata,
  input  wire logic        read_underflow_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a write of one to the flag, taken at this edge
  wire clr_hit = req && !ack && we && idx == IDX_UNDERFLOW && wdata[UNDERFLOW_BIT];

  // answer is a single pulse, one cycle after the request is taken
  AST_ACK_ONE: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  AST_ACK_NEXT: assert property (req && !ack |=> ack) else $error("ack late");
  AST_ACK_CAUSE: assert property (ack |-> $past(req)) else $error("ack without request");
  // request drops once answered and holds its qualifiers meanwhile
  AST_REQ_DROP: assert property (ack |=> !req) else $error("request kept after ack");
  AST_REQ_HOLD: assert property (req && !ack |=> $stable({we, idx, wdata}))
    else $error("request changed while pending");
  // write answers carry no data
  AST_WR_ZERO: assert property (ack && we |-> rdata == 32'h0) else $error("rdata on write");
  // no bank register is wider than sixteen bits
  AST_RSV_HIGH: assert property (ack && !we |-> rdata[31:16] == 16'h0)
    else $error("reserved high bits set");
  // realign bits are strobes and never read back
  AST_START_RSV: assert property (ack && !we && (idx == IDX_RESIZE_START ||
    idx == IDX_STAT_START) |-> rdata[15:13] == 3'h0) else $error("start bits");
  // sticky flag only falls through a write of one
  AST_FLAG_HOLD: assert property (read_underflow_flag && !clr_hit |=> read_underflow_flag)
    else $error("flag lost");
  AST_FLAG_CLR: assert property ($fell(read_underflow_flag) |-> $past(clr_hit))
    else $error("flag fell without clear");
endmodule
`default_nettype wire

// ==== bench/test_image_pipe_input_if_config.sv ====
// testbench driving both link ends through apb and the pipe-side pins
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module test_image_pipe_input_if_config
  import ipc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // apb side
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // pipe-side inputs
  logic        hsync_in, vsync_in, data_valid, ext_write_enable;
  logic        port_vstart, sensor_vstart, underflow_corrupt;
  logic [11:0] gained_sample;
  // pipe-side outputs
  logic        hsync_active, vsync_active, pixel_valid, interface_irq, read_rate_tick;
  logic        sync_realign, statistics_sync_realign, input_type_select, dark_subtract_order;
  logic        live_correction_on, memory_correction_on, pixel_drop_select, smoothing_select;
  logic [11:0] clipped_sample, live_defect_limit, memory_defect_limit;
  logic [12:0] resize_start_field, statistics_resize_start;
  logic [6:0]  resize_step;
  // bookkeeping
  int          fail_count = 0, n_tests = 0, ticks = 0, n_aln = 0, n_saln = 0;

  ipc_link_if link();
  ipc_ctrl i_ipc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .link(link));
  ipc_bank i_ipc_bank (.pclk, .presetn, .link(link), .hsync_in, .vsync_in, .data_valid,
    .ext_write_enable, .port_vstart, .sensor_vstart, .gained_sample, .underflow_corrupt,
    .hsync_active, .vsync_active, .pixel_valid, .interface_irq, .clipped_sample,
    .read_rate_tick, .sync_realign, .statistics_sync_realign, .input_type_select,
    .dark_subtract_order, .resize_start_field, .statistics_resize_start,
    .live_correction_on, .live_defect_limit, .memory_correction_on,
    .memory_defect_limit, .pixel_drop_select, .smoothing_select, .resize_step);
  ipc_chk i_ipc_chk (.pclk, .presetn, .req(link.req), .we(link.we), .idx(link.idx),
    .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
    .read_underflow_flag(link.read_underflow_flag));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // pulse counters sample on the falling edge so the main thread never races them
  always @(negedge pclk) begin
    if (read_rate_tick === 1'b1) ticks++;
    if (sync_realign === 1'b1) n_aln++;
    if (statistics_sync_realign === 1'b1) n_saln++;
  end

  // byte address of a bank register
  function automatic logic [11:0] ra(input int i);
    return 12'(i * 4);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; an idle cycle first keeps each strobe to one assignment per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    #100us;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] v;
    logic        e;
    int          t;
    static logic [31:0] rst_v [9] = '{0, 0, 'hfff, 0, 0, 0, 0, 'h10, 0};
    static logic [31:0] msk [9] = '{'h3f, 'h1fff, 'hfff, 0, 'hffff, 'h1fff, 'h1fff,
                                    'h370, 'h1fff};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {hsync_in, vsync_in, data_valid, ext_write_enable} = '0;
    {port_vstart, sensor_vstart, underflow_corrupt, gained_sample} = '0;
    presetn = 1'b0;
    cyc(16);
    presetn <= 1'b1;
    // reset values, then all-ones writes (step 0x70 in the statistics register) read back through the field masks
    for (int i = 0; i < 9; i++) begin
      rd(ra(i), v);
      `CHK(v, rst_v[i])
    end
    `CHK(resize_step, 7'h10)
    for (int i = 0; i < 9; i++) begin
      // the statistics step stays in its legal range; every bit above 7 is set, bits 7 and 3-0 are clear
      wr(ra(i), (i == 7) ? 32'hffff_ff70 : 32'hffff_ffff);
      rd(ra(i), v);
      `CHK(v, msk[i])
    end
    `CHK(n_aln, 1)
    `CHK(n_saln, 1)
    `CHK({resize_start_field, statistics_resize_start}, {13'h1fff, 13'h1fff})
    `CHK({live_correction_on, live_defect_limit}, {1'b1, 12'hfff})
    `CHK({memory_correction_on, memory_defect_limit}, {1'b1, 12'hfff})
    `CHK({dark_subtract_order, input_type_select}, 2'b11)
    `CHK({pixel_drop_select, smoothing_select, resize_step}, {2'b11, 7'h70})
    // widest legal step with drop and smoothing off
    wr(ra(7), 32'h0000_0070);
    `CHK({pixel_drop_select, smoothing_select, resize_step}, {2'b00, 7'h70})
    // sync polarity and interrupt origin, both settings
    // only the selected origin pulses, so a wrong select shows up as a zero
    hsync_in <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      port_vstart <= (b == 0);
      sensor_vstart <= (b == 1);
      wr(ra(0), b ? 32'h7 : 32'h0);
      cyc(2);
      `CHK({hsync_active, vsync_active, interface_irq}, b ? 3'b011 : 3'b101)
    end
    port_vstart <= 1'b0;
    sensor_vstart <= 1'b0;
    // external qualify and input type against enable and source bit
    data_valid <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      // the type bit goes to zero before the source bit is set, as software must
      wr(ra(0), k ? 32'h10 : 32'h18);
      wr(ADDR_CTRL, k ? 32'h5 : 32'h0);
      cyc(2);
      `CHK({pixel_valid, input_type_select}, k ? 2'b00 : 2'b11)
    end
    ext_write_enable <= 1'b1;
    cyc(2);
    `CHK(pixel_valid, 1'b1)
    // clipping above and below the limit
    wr(ra(2), 32'h100);
    gained_sample <= 12'h200;
    cyc(2);
    `CHK(clipped_sample, 12'h100)
    gained_sample <= 12'h0ff;
    cyc(2);
    `CHK(clipped_sample, 12'h0ff)
    // sticky underflow flag, ignored zero write, clearing one write
    underflow_corrupt <= 1'b1;
    cyc(1);
    underflow_corrupt <= 1'b0;
    cyc(3);
    rd(ADDR_STATUS, v);
    `CHK(v, 32'h1)
    wr(ra(3), 32'h0);
    rd(ra(3), v);
    `CHK(v, 32'h1)
    wr(ra(3), 32'h1);
    rd(ra(3), v);
    `CHK(v, 32'h0)
    // divider M=2 N=5 keeps the ratio under one half; a tick every cycle until selected
    wr(ra(4), 32'h0104);
    wr(ADDR_CTRL, 32'h0);
    t = ticks;
    cyc(20);
    `CHK(ticks - t, 20)
    wr(ADDR_CTRL, 32'h2);
    cyc(8);
    t = ticks;
    cyc(40);
    `CHK(ticks - t, 16)
    // unmapped and misaligned addresses are refused
    apb(1'b0, 12'h048, 32'h0, v, e);
    `CHK({e, v}, {1'b1, 32'h0})
    apb(1'b1, 12'h002, 32'h1, v, e);
    `CHK(e, 1'b1)
    tally_and_finish();
  end
endmodule
`default_nettype wire
